/* design/dlbs_pkg.sv */
// Shared constants and types for the die-to-die link bring-up controller.
`default_nettype none
package dlbs_pkg;
	// ************************************************************
	// Geometry
	// ************************************************************
	localparam int NSLICE    = 8;
	localparam int PAT_W     = 16;
	localparam int AV_AW     = 5;
	localparam int APB_AW    = 12;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_NS       = 40;
	localparam int RST_HOLD_NS  = 1000;
	localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_W       = 8;
	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [AV_AW-1:0] OFS_CTRL    = 5'h00;
	localparam logic [AV_AW-1:0] OFS_DIR     = 5'h04;
	localparam logic [AV_AW-1:0] OFS_PAT     = 5'h08;
	localparam logic [AV_AW-1:0] OFS_TXCFG_A = 5'h0c;
	localparam logic [AV_AW-1:0] OFS_TXCFG_D = 5'h10;
	localparam logic [AV_AW-1:0] OFS_STATUS  = 5'h14;
	localparam logic [AV_AW-1:0] OFS_RXCFG_A = 5'h18;
	localparam logic [AV_AW-1:0] OFS_RXCFG_D = 5'h1c;
	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int CTRL_RUN     = 0;
	localparam int CTRL_RESTART = 1;
	localparam int CTRL_CFG_EN  = 2;
	localparam int CTRL_NEED_EN = 3;
	localparam int ST_DONE      = 4;
	localparam int ST_FAULT     = 5;
	localparam int ST_APB_ERR   = 6;
	localparam int ST_UP_LSB    = 8;
	localparam logic [3:0]        CTRL_RST = 4'h0;
	localparam logic [NSLICE-1:0] DIR_RST  = 8'h0f;
	localparam logic [PAT_W-1:0]  PAT_RST  = 16'h00ff;
	// ************************************************************
	// Bring-up phases
	// ************************************************************
	typedef enum logic [3:0] {
		PH_IDLE    = 4'b0000,
		PH_RST_ALL = 4'b0001,
		PH_TX_REL  = 4'b0010,
		PH_TX_CFG  = 4'b0011,
		PH_TX_EN   = 4'b0100,
		PH_TX_WAIT = 4'b0101,
		PH_TRAIN   = 4'b0110,
		PH_RX_REL  = 4'b0111,
		PH_RX_CFG  = 4'b1000,
		PH_RX_EN   = 4'b1001,
		PH_RX_WAIT = 4'b1010,
		PH_UP      = 4'b1011
	} dlbs_phase_t;
	typedef enum logic [1:0] {
		AP_IDLE   = 2'b00,
		AP_SETUP  = 2'b01,
		AP_ACCESS = 2'b10
	} dlbs_apb_t;
endpackage : dlbs_pkg
`default_nettype wire

/* design/dlbs_apb_master.sv */
// Single-write APB master used for slice configuration.
`default_nettype none
module dlbs_apb_master (
	input  wire logic                       ref_clk,
	input  wire logic                       resetn,
	input  wire logic                       start,
	input  wire logic [dlbs_pkg::APB_AW-1:0] addr,
	input  wire logic [31:0]                wdata,
	output logic                            done,
	output logic                            err,
	output logic                            psel,
	output logic                            penable,
	output logic                            pwrite,
	output logic [dlbs_pkg::APB_AW-1:0]     paddr,
	output logic [31:0]                     pwdata,
	input  wire logic                       pready,
	input  wire logic                       pslverr
);
	dlbs_pkg::dlbs_apb_t state_reg;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= dlbs_pkg::AP_IDLE;
			paddr     <= '0;
			pwdata    <= '0;
			done      <= 1'b0;
			err       <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state_reg)
				dlbs_pkg::AP_IDLE: begin
					if (start) begin
						paddr     <= addr;
						pwdata    <= wdata;
						state_reg <= dlbs_pkg::AP_SETUP;
					end
				end
				dlbs_pkg::AP_SETUP: begin
					state_reg <= dlbs_pkg::AP_ACCESS;
				end
				dlbs_pkg::AP_ACCESS: begin
					if (pready) begin
						done      <= 1'b1;
						err       <= pslverr;
						state_reg <= dlbs_pkg::AP_IDLE;
					end
				end
				default: state_reg <= dlbs_pkg::AP_IDLE;
			endcase
		end
	end

	assign psel    = (state_reg != dlbs_pkg::AP_IDLE);
	assign penable = (state_reg == dlbs_pkg::AP_ACCESS);
	assign pwrite  = 1'b1;
endmodule : dlbs_apb_master
`default_nettype wire

/* design/dlbs_link_ctrl.sv */
// Link controller that brings up transmit and then receive PHY slices.
//
// Register access over Avalon-MM and the address map are this design's own decisions.
`default_nettype none
module dlbs_link_ctrl (
	input  wire logic                        ref_clk,
	input  wire logic                        resetn,
	// Avalon-MM slave
	input  wire logic [dlbs_pkg::AV_AW-1:0]  avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output logic [31:0]                      avs_readdata,
	output logic                             avs_waitrequest,
	// Slice control
	output logic [dlbs_pkg::NSLICE-1:0]      slice_reset_low,
	output logic [dlbs_pkg::NSLICE-1:0]      slice_enable,
	input  wire logic [dlbs_pkg::NSLICE-1:0] slice_up_flag,
	// Link layer control
	output logic                             train_send,
	output logic [dlbs_pkg::PAT_W-1:0]       train_pattern,
	output logic                             bond_start,
	// APB to slices
	output logic                             psel,
	output logic                             penable,
	output logic                             pwrite,
	output logic [dlbs_pkg::APB_AW-1:0]      paddr,
	output logic [31:0]                      pwdata,
	input  wire logic                        pready,
	input  wire logic                        pslverr
);
	// ************************************************************
	// Software registers
	// ************************************************************
	logic [3:0]                   ctrl_reg;
	logic [dlbs_pkg::NSLICE-1:0]  dir_reg;
	logic [dlbs_pkg::APB_AW-1:0]  txcfg_a_reg;
	logic [31:0]                  txcfg_d_reg;
	logic [dlbs_pkg::APB_AW-1:0]  rxcfg_a_reg;
	logic [31:0]                  rxcfg_d_reg;
	logic                         fault_reg;
	logic                         apb_err_reg;
	logic                         ack_reg;
	logic                         restart_reg;
	logic                         dir_chg_reg;
	dlbs_pkg::dlbs_phase_t        phase_reg;
	logic [dlbs_pkg::HOLD_W-1:0]  hold_reg;
	logic                         apb_busy_reg;
	logic                         apb_start;
	logic                         apb_done;
	logic                         apb_err;
	logic                         wr_hit;
	logic                         fault_evt;
	logic [dlbs_pkg::NSLICE-1:0]  tx_mask;
	logic [dlbs_pkg::NSLICE-1:0]  rx_mask;
	logic                         tx_all_up;
	logic                         rx_all_up;
	logic [31:0]                  rd_mux;

	// Writes land at the edge after the wait state, when waitrequest is low, as the master expects.
	assign wr_hit          = avs_write & ack_reg;
	// One wait state: every access is answered at the second edge.
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (avs_read | avs_write) & ~ack_reg;
		end
	end

	always_comb begin
		rd_mux = '0;
		case (avs_address)
			dlbs_pkg::OFS_CTRL:    rd_mux[3:0] = ctrl_reg & 4'hd;
			dlbs_pkg::OFS_DIR:     rd_mux[dlbs_pkg::NSLICE-1:0] = dir_reg;
			dlbs_pkg::OFS_PAT:     rd_mux[dlbs_pkg::PAT_W-1:0] = train_pattern;
			dlbs_pkg::OFS_TXCFG_A: rd_mux[dlbs_pkg::APB_AW-1:0] = txcfg_a_reg;
			dlbs_pkg::OFS_TXCFG_D: rd_mux = txcfg_d_reg;
			dlbs_pkg::OFS_RXCFG_A: rd_mux[dlbs_pkg::APB_AW-1:0] = rxcfg_a_reg;
			dlbs_pkg::OFS_RXCFG_D: rd_mux = rxcfg_d_reg;
			dlbs_pkg::OFS_STATUS: begin
				rd_mux[3:0]                  = phase_reg;
				rd_mux[dlbs_pkg::ST_DONE]    = (phase_reg == dlbs_pkg::PH_UP);
				rd_mux[dlbs_pkg::ST_FAULT]   = fault_reg;
				rd_mux[dlbs_pkg::ST_APB_ERR] = apb_err_reg;
				rd_mux[dlbs_pkg::ST_UP_LSB +: dlbs_pkg::NSLICE] = slice_up_flag;
			end
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			avs_readdata <= '0;
		end else if (avs_read & ~ack_reg) begin
			avs_readdata <= rd_mux;
		end
	end

	// Byte lane 0 carries every narrow field; wider fields honour all lanes.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_reg      <= dlbs_pkg::CTRL_RST;
			dir_reg       <= dlbs_pkg::DIR_RST;
			train_pattern <= dlbs_pkg::PAT_RST;
			txcfg_a_reg   <= '0;
			txcfg_d_reg   <= '0;
			rxcfg_a_reg   <= '0;
			rxcfg_d_reg   <= '0;
			restart_reg   <= 1'b0;
			dir_chg_reg   <= 1'b0;
		end else begin
			// A restart that meets a busy configuration write waits for it to finish.
			restart_reg <= restart_reg & apb_busy_reg;
			dir_chg_reg <= dir_chg_reg & apb_busy_reg;
			if (wr_hit) begin
				case (avs_address)
					dlbs_pkg::OFS_CTRL: begin
						if (avs_byteenable[0]) begin
							ctrl_reg    <= avs_writedata[3:0] & 4'hd;
							restart_reg <= avs_writedata[dlbs_pkg::CTRL_RESTART];
						end
					end
					dlbs_pkg::OFS_DIR: begin
						if (avs_byteenable[0]) begin
							dir_reg     <= avs_writedata[dlbs_pkg::NSLICE-1:0];
							dir_chg_reg <= (avs_writedata[dlbs_pkg::NSLICE-1:0] != dir_reg);
						end
					end
					dlbs_pkg::OFS_PAT: begin
						if (avs_byteenable[0]) train_pattern[7:0] <= avs_writedata[7:0];
						if (avs_byteenable[1]) train_pattern[15:8] <= avs_writedata[15:8];
					end
					dlbs_pkg::OFS_TXCFG_A: begin
						if (avs_byteenable[0]) txcfg_a_reg[7:0] <= avs_writedata[7:0];
						if (avs_byteenable[1]) txcfg_a_reg[11:8] <= avs_writedata[11:8];
					end
					dlbs_pkg::OFS_RXCFG_A: begin
						if (avs_byteenable[0]) rxcfg_a_reg[7:0] <= avs_writedata[7:0];
						if (avs_byteenable[1]) rxcfg_a_reg[11:8] <= avs_writedata[11:8];
					end
					dlbs_pkg::OFS_TXCFG_D: begin
						for (int b = 0; b < 4; b++) begin
							if (avs_byteenable[b]) txcfg_d_reg[8*b +: 8] <= avs_writedata[8*b +: 8];
						end
					end
					dlbs_pkg::OFS_RXCFG_D: begin
						for (int b = 0; b < 4; b++) begin
							if (avs_byteenable[b]) rxcfg_d_reg[8*b +: 8] <= avs_writedata[8*b +: 8];
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ************************************************************
	// Sticky status, set wins over write-one-to-clear
	// ************************************************************
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			fault_reg   <= 1'b0;
			apb_err_reg <= 1'b0;
		end else begin
			if (fault_evt) begin
				fault_reg <= 1'b1;
			end else if (wr_hit && avs_address == dlbs_pkg::OFS_STATUS && avs_byteenable[0]
			             && avs_writedata[dlbs_pkg::ST_FAULT]) begin
				fault_reg <= 1'b0;
			end
			if (apb_done && apb_err) begin
				apb_err_reg <= 1'b1;
			end else if (wr_hit && avs_address == dlbs_pkg::OFS_STATUS && avs_byteenable[0]
			             && avs_writedata[dlbs_pkg::ST_APB_ERR]) begin
				apb_err_reg <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Bring-up sequence
	// ************************************************************
	assign tx_mask   = dir_reg;
	assign rx_mask   = ~dir_reg;
	assign tx_all_up = &(slice_up_flag | ~tx_mask);
	assign rx_all_up = &(slice_up_flag | ~rx_mask);

	// A transmit slice losing ready once training runs, or any slice once up.
	always_comb begin
		fault_evt = 1'b0;
		case (phase_reg)
			dlbs_pkg::PH_TRAIN, dlbs_pkg::PH_RX_REL, dlbs_pkg::PH_RX_CFG,
			dlbs_pkg::PH_RX_EN, dlbs_pkg::PH_RX_WAIT: fault_evt = ~tx_all_up;
			dlbs_pkg::PH_UP: fault_evt = ~tx_all_up | ~rx_all_up;
			default: fault_evt = 1'b0;
		endcase
	end

	assign apb_start = ~apb_busy_reg & ctrl_reg[dlbs_pkg::CTRL_CFG_EN] & ctrl_reg[dlbs_pkg::CTRL_RUN]
	                   & ~restart_reg & ~dir_chg_reg
	                   & ((phase_reg == dlbs_pkg::PH_TX_CFG) | (phase_reg == dlbs_pkg::PH_RX_CFG));

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			phase_reg    <= dlbs_pkg::PH_IDLE;
			hold_reg     <= '0;
			apb_busy_reg <= 1'b0;
		end else if (!ctrl_reg[dlbs_pkg::CTRL_RUN]) begin
			phase_reg    <= dlbs_pkg::PH_IDLE;
			apb_busy_reg <= apb_busy_reg & ~apb_done;
		end else if ((restart_reg | dir_chg_reg | fault_evt)
		             && phase_reg != dlbs_pkg::PH_IDLE && !apb_busy_reg) begin
			phase_reg <= dlbs_pkg::PH_RST_ALL;
			hold_reg  <= '0;
		end else begin
			case (phase_reg)
				dlbs_pkg::PH_IDLE: begin
					phase_reg <= dlbs_pkg::PH_RST_ALL;
					hold_reg  <= '0;
				end
				dlbs_pkg::PH_RST_ALL: begin
					hold_reg <= hold_reg + 1'b1;
					if (hold_reg == dlbs_pkg::HOLD_W'(dlbs_pkg::RST_HOLD_CYC - 1)) begin
						phase_reg <= dlbs_pkg::PH_TX_REL;
					end
				end
				dlbs_pkg::PH_TX_REL: phase_reg <= dlbs_pkg::PH_TX_CFG;
				dlbs_pkg::PH_TX_CFG, dlbs_pkg::PH_RX_CFG: begin
					if (apb_start) begin
						apb_busy_reg <= 1'b1;
					end else if (apb_busy_reg) begin
						if (apb_done) begin
							apb_busy_reg <= 1'b0;
							phase_reg    <= (phase_reg == dlbs_pkg::PH_TX_CFG) ?
							                dlbs_pkg::PH_TX_EN : dlbs_pkg::PH_RX_EN;
						end
					end else begin
						phase_reg <= (phase_reg == dlbs_pkg::PH_TX_CFG) ?
						             dlbs_pkg::PH_TX_EN : dlbs_pkg::PH_RX_EN;
					end
				end
				dlbs_pkg::PH_TX_EN: phase_reg <= dlbs_pkg::PH_TX_WAIT;
				dlbs_pkg::PH_TX_WAIT: begin
					if (tx_all_up) phase_reg <= dlbs_pkg::PH_TRAIN;
				end
				dlbs_pkg::PH_TRAIN: phase_reg <= dlbs_pkg::PH_RX_REL;
				dlbs_pkg::PH_RX_REL: phase_reg <= dlbs_pkg::PH_RX_CFG;
				dlbs_pkg::PH_RX_EN: phase_reg <= dlbs_pkg::PH_RX_WAIT;
				dlbs_pkg::PH_RX_WAIT: begin
					if (rx_all_up) phase_reg <= dlbs_pkg::PH_UP;
				end
				dlbs_pkg::PH_UP: phase_reg <= dlbs_pkg::PH_UP;
				default: phase_reg <= dlbs_pkg::PH_IDLE;
			endcase
		end
	end

	// ************************************************************
	// Slice and link layer outputs, registered from the phase, the direction masks and CTRL_NEED_EN
	// ************************************************************
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			slice_reset_low <= '0;
			slice_enable    <= '0;
			train_send      <= 1'b0;
			bond_start      <= 1'b0;
		end else begin
			case (phase_reg)
				dlbs_pkg::PH_IDLE, dlbs_pkg::PH_RST_ALL: begin
					slice_reset_low <= '0;
					slice_enable    <= '0;
					train_send      <= 1'b0;
					bond_start      <= 1'b0;
				end
				dlbs_pkg::PH_TX_REL, dlbs_pkg::PH_TX_CFG: begin
					slice_reset_low <= tx_mask;
				end
				dlbs_pkg::PH_TX_EN: begin
					if (ctrl_reg[dlbs_pkg::CTRL_NEED_EN]) slice_enable <= tx_mask;
				end
				dlbs_pkg::PH_TRAIN: begin
					train_send <= 1'b1;
				end
				dlbs_pkg::PH_RX_REL: begin
					slice_reset_low <= tx_mask | rx_mask;
				end
				dlbs_pkg::PH_RX_EN: begin
					if (ctrl_reg[dlbs_pkg::CTRL_NEED_EN]) slice_enable <= tx_mask | rx_mask;
				end
				dlbs_pkg::PH_UP: begin
					bond_start <= 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// ************************************************************
	// Configuration port
	// ************************************************************
	dlbs_apb_master u_apb (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.start   (apb_start),
		.addr    ((phase_reg == dlbs_pkg::PH_TX_CFG) ? txcfg_a_reg : rxcfg_a_reg),
		.wdata   ((phase_reg == dlbs_pkg::PH_TX_CFG) ? txcfg_d_reg : rxcfg_d_reg),
		.done    (apb_done),
		.err     (apb_err),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pready  (pready),
		.pslverr (pslverr)
	);
endmodule : dlbs_link_ctrl
`default_nettype wire

/* tb/dlbs_phy_model.sv */
// Behavioural model of the PHY slices and their APB configuration port.
`default_nettype none
module dlbs_phy_model (
	input  wire logic                        ref_clk,
	input  wire logic                        resetn,
	input  wire logic [dlbs_pkg::NSLICE-1:0] slice_reset_low,
	input  wire logic [dlbs_pkg::NSLICE-1:0] slice_enable,
	input  wire logic [dlbs_pkg::NSLICE-1:0] dir,
	input  wire logic [dlbs_pkg::NSLICE-1:0] drop,
	input  wire logic                        need_en,
	input  wire logic                        slow,
	input  wire logic                        train_send,
	input  wire logic                        psel,
	input  wire logic                        penable,
	output logic [dlbs_pkg::NSLICE-1:0]      slice_up_flag,
	output logic                             pready,
	output logic                             pslverr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0]                  cnt [dlbs_pkg::NSLICE];
	logic [2:0]                  lock;
	logic [1:0]                  wcnt;
	logic [dlbs_pkg::NSLICE-1:0] go;
	// ****************************************
	// Slices
	// ****************************************
	// Receive slices align only on live training data, so they wait for it.
	assign lock = slow ? 3'h6 : 3'h2;
	assign go = (slice_enable | {dlbs_pkg::NSLICE{!need_en}}) & (dir | {dlbs_pkg::NSLICE{train_send}});
	always_ff @(posedge ref_clk or negedge resetn) begin
		for (int i = 0; i < dlbs_pkg::NSLICE; i++) begin
			if (!resetn || !slice_reset_low[i]) begin
				cnt[i]           <= 3'h0;
				slice_up_flag[i] <= 1'b0;
			end else if (go[i]) begin
				if (cnt[i] != lock)
					cnt[i] <= cnt[i] + 3'h1;
				slice_up_flag[i] <= (cnt[i] == lock) && !drop[i];
			end
		end
	end
	// ****************************************
	// Configuration port
	// ****************************************
	// Slow mode stretches every access so the master must hold its request.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn || !(psel && penable) || pready)
			wcnt <= 2'h0;
		else
			wcnt <= wcnt + 2'h1;
	end
	assign pready  = psel && penable && (wcnt == (slow ? 2'h3 : 2'h0));
	assign pslverr = 1'b0;
endmodule : dlbs_phy_model
`default_nettype wire

/* tb/dlbs_link_ctrl_asserts.sv */
// Concurrent checks on the link bring-up controller ports.
`default_nettype none
module dlbs_link_ctrl_asserts (
	input wire logic                        ref_clk,
	input wire logic                        resetn,
	input wire logic                        avs_read,
	input wire logic                        avs_write,
	input wire logic                        avs_waitrequest,
	input wire logic [dlbs_pkg::NSLICE-1:0] slice_reset_low,
	input wire logic [dlbs_pkg::NSLICE-1:0] slice_enable,
	input wire logic [dlbs_pkg::NSLICE-1:0] slice_up_flag,
	input wire logic                        train_send,
	input wire logic                        bond_start,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pwrite,
	input wire logic [dlbs_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0]                 pwdata,
	input wire logic                        pready
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	logic [7:0] low_cnt;
	// ****************************************
	// Helpers
	// ****************************************
	// Saturates so a long stop cannot wrap back below the hold time.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			low_cnt <= 8'h00;
		else if (slice_reset_low != '0)
			low_cnt <= 8'h00;
		else if (low_cnt != 8'hff)
			low_cnt <= low_cnt + 8'h01;
	end
	sequence s_apb_setup;
		psel && !penable;
	endsequence
	sequence s_apb_access;
		psel && penable;
	endsequence
	// ****************************************
	// Assertions
	// ****************************************
	a_reset_quiet: assert property ($rose(resetn) |-> slice_reset_low == '0 && !train_send)
		else $error("slice reset not held after reset");
	a_hold_time: assert property ((slice_reset_low != '0) && ($past(slice_reset_low) == '0)
		|-> low_cnt >= 8'(dlbs_pkg::RST_HOLD_CYC)) else $error("slices released too early");
	a_train_ready: assert property ($rose(train_send) |-> ($past(slice_reset_low) != '0)
		&& (($past(slice_up_flag) | ~$past(slice_reset_low)) == '1)) else $error("training early");
	a_rx_release: assert property ((($past(slice_reset_low) != '0)
		&& ((slice_reset_low & ~$past(slice_reset_low)) != '0)) |-> $past(train_send))
		else $error("receive slices released before training");
	a_bond_ready: assert property ($rose(bond_start) |-> train_send
		&& slice_reset_low == '1 && $past(slice_up_flag) == '1) else $error("bonding early");
	a_enable_rel: assert property ((slice_enable & ~slice_reset_low) == '0)
		else $error("slice enabled while in reset");
	a_apb_access: assert property (s_apb_setup |=> s_apb_access)
		else $error("APB setup without access");
	a_apb_hold: assert property (psel && penable && !pready |=>
		psel && penable && $stable(paddr) && $stable(pwdata)) else $error("APB access dropped");
	a_apb_write: assert property (psel |-> pwrite)
		else $error("APB access not a write");
	a_fault_restart: assert property (bond_start && (($past(slice_up_flag) & ~slice_up_flag) != '0)
		|-> ##[1:4] (slice_reset_low == '0)) else $error("ready drop did not restart");
	a_avs_wait: assert property ($rose(avs_read || avs_write)
		|-> avs_waitrequest ##1 !avs_waitrequest) else $error("bus wait state wrong");
endmodule : dlbs_link_ctrl_asserts
bind dlbs_link_ctrl dlbs_link_ctrl_asserts u_chk (.ref_clk, .resetn, .avs_read, .avs_write,
	.avs_waitrequest, .slice_reset_low, .slice_enable, .slice_up_flag, .train_send,
	.bond_start, .psel, .penable, .pwrite, .paddr, .pwdata, .pready);
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the link bring-up controller.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic                        ref_clk = 1'b0;
	logic                        resetn = 1'b0;
	logic [dlbs_pkg::AV_AW-1:0]  avs_address = '0;
	logic                        avs_read = 1'b0;
	logic                        avs_write = 1'b0;
	logic [31:0]                 avs_writedata = '0;
	logic [3:0]                  avs_byteenable = 4'hf;
	logic [31:0]                 avs_readdata;
	logic                        avs_waitrequest, train_send, bond_start, psel, penable, pwrite;
	logic                        pready, pslverr, need_en = 1'b0, slow = 1'b0, train_q = 1'b0;
	logic [dlbs_pkg::NSLICE-1:0] slice_reset_low, slice_enable, slice_up_flag;
	logic [dlbs_pkg::NSLICE-1:0] dir = 8'h0f, drop = 8'h00, tx_seen = 8'h00;
	logic [dlbs_pkg::PAT_W-1:0]  train_pattern;
	logic [dlbs_pkg::APB_AW-1:0] paddr;
	logic [dlbs_pkg::APB_AW-1:0] apb_a [2];
	logic [31:0]                 apb_d [2];
	logic [31:0]                 pwdata, rd, lfsr_q = 32'h00010e63;
	int                          apb_n = 0, failures = 0, checks = 0, cycles = 0;
	dlbs_link_ctrl DUT (.ref_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .slice_reset_low, .slice_enable,
		.slice_up_flag, .train_send, .train_pattern, .bond_start, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pready, .pslverr);
	dlbs_phy_model u_phy (.ref_clk, .resetn, .slice_reset_low, .slice_enable, .dir, .drop,
		.need_en, .slow, .train_send, .psel, .penable, .slice_up_flag, .pready, .pslverr);
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end
	// ****************************************
	// Monitors and helpers
	// ****************************************
	// Slices already out of reset when training starts are the transmit set.
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		train_q <= train_send;
		if (train_send && !train_q)
			tx_seen <= slice_reset_low;
		if (psel && penable && pready) begin
			apb_a[apb_n % 2] <= paddr;
			apb_d[apb_n % 2] <= pwdata;
			apb_n <= apb_n + 1;
		end
		if (cycles == 20000) begin
			failures++;
			results();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	function automatic logic [31:0] st(input logic [3:0] ph, input logic f);
		return 32'({8'hff, 2'b00, f, 1'b1, ph});
	endfunction : st
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic av(input logic wr, input logic [dlbs_pkg::AV_AW-1:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= !wr;
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask : av
	task automatic wait_bond(input logic v);
		int n = 0;
		while (bond_start !== v && n < 3000) begin
			@(negedge ref_clk);
			n++;
		end
		chk(32'(n < 3000), 32'h1);
	endtask : wait_bond
	task automatic bringup(input int i);
		logic [7:0]  d;
		logic [15:0] p;
		logic [11:0] ta;
		logic [11:0] ra;
		lfsr_q = lfsr(lfsr_q);
		d = (i == 0) ? 8'h01 : (i == 3) ? 8'h7f : lfsr_q[7:0];
		p = lfsr_q[23:8];
		lfsr_q = lfsr(lfsr_q);
		ta = lfsr_q[11:0];
		ra = lfsr_q[27:16];
		if (d == 8'h00 || d == 8'hff)
			d = 8'h3c;
		dir <= d;
		slow <= lfsr_q[31];
		need_en <= i[1];
		apb_n = 0;
		av(1'b1, dlbs_pkg::OFS_DIR, 32'(d));
		av(1'b1, dlbs_pkg::OFS_PAT, 32'(p));
		av(1'b1, dlbs_pkg::OFS_TXCFG_A, 32'(ta));
		av(1'b1, dlbs_pkg::OFS_TXCFG_D, lfsr_q);
		av(1'b1, dlbs_pkg::OFS_RXCFG_A, 32'(ra));
		av(1'b1, dlbs_pkg::OFS_RXCFG_D, ~lfsr_q);
		av(1'b1, dlbs_pkg::OFS_CTRL, 32'({i[1], i[0], 2'b01}));
		wait_bond(1'b1);
		chk(32'(tx_seen), 32'(d));
		chk(32'(train_pattern), 32'(p));
		chk(32'(slice_reset_low), 32'hff);
		chk(32'(slice_enable), i[1] ? 32'hff : 32'h0);
		chk(32'(apb_n), i[0] ? 32'h2 : 32'h0);
		if (i[0]) begin
			chk(32'({apb_a[0], apb_a[1]}), 32'({ta, ra}));
			chk(apb_d[0], lfsr_q);
			chk(apb_d[1], ~lfsr_q);
		end
		av(1'b0, dlbs_pkg::OFS_STATUS, 32'h0);
		chk(rd, st(4'hb, 1'b0));
	endtask : bringup
	task automatic results();
		if (failures == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		@(negedge ref_clk);
		chk(32'(slice_reset_low), 32'h0);
		av(1'b0, dlbs_pkg::OFS_CTRL, 32'h0);
		chk(rd, 32'(dlbs_pkg::CTRL_RST));
		av(1'b0, dlbs_pkg::OFS_DIR, 32'h0);
		chk(rd, 32'(dlbs_pkg::DIR_RST));
		av(1'b0, dlbs_pkg::OFS_PAT, 32'h0);
		chk(rd, 32'(dlbs_pkg::PAT_RST));
		av(1'b0, dlbs_pkg::OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		for (int i = 0; i < 4; i++) begin
			bringup(i);
			if (i < 3) begin
				av(1'b1, dlbs_pkg::OFS_CTRL, 32'h0);
				av(1'b0, dlbs_pkg::OFS_STATUS, 32'h0);
				chk(32'(rd[3:0]), 32'h0);
				chk(32'(slice_reset_low), 32'h0);
			end
		end
		apb_n = 0;
		dir <= 8'h80;
		av(1'b1, dlbs_pkg::OFS_DIR, 32'h80);
		wait_bond(1'b0);
		wait_bond(1'b1);
		chk(32'(tx_seen), 32'h80);
		chk(32'(apb_n), 32'h2);
		lfsr_q = lfsr(lfsr_q);
		drop <= 8'h01 << lfsr_q[2:0];
		wait_bond(1'b0);
		av(1'b0, dlbs_pkg::OFS_STATUS, 32'h0);
		chk(32'(rd[dlbs_pkg::ST_FAULT]), 32'h1);
		drop <= 8'h00;
		wait_bond(1'b1);
		av(1'b1, dlbs_pkg::OFS_CTRL, 32'h0f);
		wait_bond(1'b0);
		wait_bond(1'b1);
		av(1'b1, dlbs_pkg::OFS_STATUS, 32'h20);
		av(1'b0, dlbs_pkg::OFS_STATUS, 32'h0);
		chk(rd, st(4'hb, 1'b0));
		results();
	end
endmodule : tb_top
`default_nettype wire
